// file: hdl/twsp_pkg.sv
package twsp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  TWSP_IDX_SC   = 8'hE2;
    localparam logic [7:0]  TWSP_IDX_OA   = 8'hE3;
    localparam logic [7:0]  TWSP_IDX_DS   = 8'hE4;
    localparam logic [7:0]  TWSP_IDX_FLAG = 8'hE5;

    localparam int          TWSP_AW       = 12;
    localparam logic [11:0] TWSP_ADDR_SC   = {2'h0, TWSP_IDX_SC, 2'h0};
    localparam logic [11:0] TWSP_ADDR_OA   = {2'h0, TWSP_IDX_OA, 2'h0};
    localparam logic [11:0] TWSP_ADDR_DS   = {2'h0, TWSP_IDX_DS, 2'h0};
    localparam logic [11:0] TWSP_ADDR_FLAG = {2'h0, TWSP_IDX_FLAG, 2'h0};

    // Status and control field positions
    localparam int TWSP_B_ACK_GENERATE_ENABLE  = 7;
    localparam int TWSP_B_EN    = 6;
    localparam int TWSP_B_FEN   = 5;
    localparam int TWSP_B_GC    = 4;
    localparam int TWSP_B_DIR   = 3;
    localparam int TWSP_B_BUSY  = 2;
    localparam int TWSP_B_SAM   = 1;
    localparam int TWSP_B_LAST  = 0;
    localparam int TWSP_B_CLR   = 0;

    localparam logic [7:0] TWSP_SC_RST = 8'h00;
    localparam logic [6:0] TWSP_OA_RST = 7'h00;
    localparam logic [7:0] TWSP_DS_RST = 8'h00;
    localparam logic [6:0] TWSP_GC_ADDR = 7'h00;
    localparam logic [3:0] TWSP_BYTE_BITS = 4'h8;

    // Timing: shortest bit at fast speed versus the system clock
    localparam int TWSP_CLK_NS      = 100;
    localparam int TWSP_STD_KBPS    = 100;
    localparam int TWSP_FAST_KBPS   = 400;
    localparam int TWSP_FAST_BIT_NS = 1000000 / TWSP_FAST_KBPS;
    localparam int TWSP_FAST_BIT_CYC = TWSP_FAST_BIT_NS / TWSP_CLK_NS;
    localparam int TWSP_MIN_BIT_CYC = 8;

    typedef struct packed {
        logic scl;
        logic sda;
    } twsp_line_t;

    typedef enum logic [2:0] {
        TWSP_IDLE = 3'h0,
        TWSP_ADDR = 3'h1,
        TWSP_ACK  = 3'h2,
        TWSP_RX   = 3'h3,
        TWSP_TX   = 3'h4,
        TWSP_MACK = 3'h5
    } twsp_state_t;

endpackage

// file: hdl/twsp_sync.sv
`timescale 1ns/1ps
module twsp_sync #(
    parameter int         WIDTH     = 2,
    parameter logic [1:0] RST_LEVEL = 2'h3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } twsp_sync_st_t;

    twsp_sync_st_t    q;
    twsp_sync_st_t    n;
    logic [WIDTH-1:0] filt;

    generate
        if (WIDTH != 2) begin : g_chk
            $error("twsp_sync serves exactly two lines");
        end
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            // Only stages two and three decide; stage one feeds stage two alone
            assign filt[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
        end
    endgenerate

    always_comb begin
        n     = q;
        n.s1  = async_in;
        n.s2  = q.s1;
        n.s3  = q.s2;
        n.lvl = filt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= {RST_LEVEL, RST_LEVEL, RST_LEVEL, RST_LEVEL};
        end else begin
            q <= n;
        end
    end

    assign level = q.lvl;
endmodule // twsp_sync

// file: hdl/twsp_port.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module twsp_port
    import twsp_pkg::*;
#(
    parameter int CLK_NS = TWSP_CLK_NS
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [TWSP_AW-1:0]        paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire twsp_pkg::twsp_line_t      line_in,
    output twsp_pkg::twsp_line_t           line_out,
    output twsp_pkg::twsp_line_t           line_oe,
    input  wire logic                      irq_enable_low,
    output logic                           byte_irq
);
    import twsp_pkg::*;

    localparam int BIT_CYC = TWSP_FAST_BIT_NS / CLK_NS;

    generate
        if (BIT_CYC < TWSP_MIN_BIT_CYC) begin : g_chk
            $error("system clock too slow to sample fast-speed bits");
        end
    endgenerate

    typedef struct packed {
        twsp_state_t st;
        logic [3:0]  cnt;
        logic [7:0]  shift;
        logic [6:0]  own;
        logic        ack_en;
        logic        port_en;
        logic        flag_en;
        logic        gc;
        logic        dir;
        logic        busy;
        logic        address_match_status;
        logic        last9;
        logic        flag;
        logic        scl_d;
        logic        sda_d;
        logic        sda_oe;
        logic        scl_oe;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } twsp_core_t;

    twsp_core_t q;
    twsp_core_t n;
    logic [1:0] lvl;
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       apb_acc;
    logic       apb_wr;
    logic       hit;
    logic [7:0] rd_val;
    logic       addr_match;
    logic       gc_match;

    // Filtered lines; idle bus reads high
    twsp_sync #(
        .WIDTH     (2),
        .RST_LEVEL (2'h3)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({line_in.scl, line_in.sda}),
        .level    (lvl)
    );

    assign scl      = lvl[1];
    assign sda      = lvl[0];
    assign scl_rise = scl & ~q.scl_d;
    assign scl_fall = ~scl & q.scl_d;
    assign start_ev = scl & q.scl_d & q.sda_d & ~sda;
    assign stop_ev  = scl & q.scl_d & ~q.sda_d & sda;

    assign addr_match = (q.shift[7:1] == q.own);
    assign gc_match   = (q.shift[7:1] == TWSP_GC_ADDR);

    assign apb_acc = psel & penable;
    assign apb_wr  = apb_acc & q.pready & pwrite;

    always_comb begin
        hit    = 1'b1;
        rd_val = 8'h00;
        unique case (paddr)
            TWSP_ADDR_SC: begin
                rd_val = {q.ack_en, q.port_en, q.flag_en, q.gc,
                          q.dir, q.busy, q.address_match_status, q.last9};
            end
            TWSP_ADDR_OA: begin
                rd_val = {1'b0, q.own};
            end
            TWSP_ADDR_DS: begin
                rd_val = q.shift;
            end
            TWSP_ADDR_FLAG: begin
                rd_val = {7'h00, q.flag};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        n         = q;
        n.scl_d   = scl;
        n.sda_d   = sda;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;

        // One wait state so every answer leaves a flip-flop
        if (apb_acc && !q.pready) begin
            n.pready  = 1'b1;
            n.pslverr = ~hit;
            n.prdata  = {24'h000000, rd_val};
        end

        if (apb_wr && hit) begin
            unique case (paddr)
                TWSP_ADDR_SC: begin
                    n.ack_en  = pwdata[TWSP_B_ACK_GENERATE_ENABLE];
                    n.port_en = pwdata[TWSP_B_EN];
                    n.flag_en = pwdata[TWSP_B_FEN];
                    n.dir     = pwdata[TWSP_B_DIR];
                end
                TWSP_ADDR_OA: begin
                    if (!q.port_en) begin
                        n.own = pwdata[6:0];
                    end
                end
                TWSP_ADDR_DS: begin
                    if (q.port_en) begin
                        n.shift = pwdata[7:0];
                    end
                end
                default: begin
                    // Write one clears; a set below still wins
                    if (pwdata[TWSP_B_CLR]) begin
                        n.flag = 1'b0;
                    end
                end
            endcase
        end

        // Bus engine runs after software so hardware events win
        if (!q.port_en) begin
            n.st     = TWSP_IDLE;
            n.sda_oe = 1'b0;
            n.busy   = 1'b0;
            n.address_match_status    = 1'b0;
            n.gc     = 1'b0;
        end else if (start_ev) begin
            // A start mid-message simply restarts address reception
            n.st     = TWSP_ADDR;
            n.cnt    = 4'h0;
            n.busy   = 1'b1;
            n.address_match_status    = 1'b0;
            n.gc     = 1'b0;
            n.sda_oe = 1'b0;
        end else if (stop_ev) begin
            n.st     = TWSP_IDLE;
            n.busy   = 1'b0;
            n.address_match_status    = 1'b0;
            n.gc     = 1'b0;
            n.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                TWSP_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                TWSP_ADDR, TWSP_RX: begin
                    if (scl_rise && q.cnt < TWSP_BYTE_BITS) begin
                        n.shift = {q.shift[6:0], sda};
                        n.cnt   = q.cnt + 4'h1;
                    end
                    if (scl_fall && q.cnt == TWSP_BYTE_BITS) begin
                        if (q.st == TWSP_RX) begin
                            n.st     = TWSP_ACK;
                            n.sda_oe = q.ack_en;
                        end else if (addr_match || gc_match) begin
                            n.st     = TWSP_ACK;
                            n.address_match_status    = addr_match;
                            n.gc     = gc_match;
                            n.dir    = q.shift[0];
                            n.sda_oe = q.ack_en;
                        end else begin
                            n.st = TWSP_IDLE;
                        end
                    end
                end
                TWSP_ACK: begin
                    if (scl_rise) begin
                        n.last9 = sda;
                    end
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt    = 4'h0;
                        // Built on n.flag so a same-cycle clear holds when flags are off
                        n.flag   = n.flag | q.flag_en;
                        n.st     = q.dir ? TWSP_TX : TWSP_RX;
                    end
                end
                TWSP_TX: begin
                    // Data moves only while the clock is low
                    if (!scl) begin
                        n.sda_oe = ~q.shift[7];
                    end
                    if (scl_fall) begin
                        n.shift = {q.shift[6:0], 1'b1};
                        n.cnt   = q.cnt + 4'h1;
                        if (q.cnt == TWSP_BYTE_BITS - 4'h1) begin
                            n.st     = TWSP_MACK;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                TWSP_MACK: begin
                    if (scl_rise) begin
                        n.last9 = sda;
                    end
                    if (scl_fall) begin
                        n.flag = n.flag | q.flag_en;
                        n.cnt  = 4'h0;
                        // No acknowledge ends the read; wait for stop or start
                        n.st   = q.last9 ? TWSP_IDLE : TWSP_TX;
                    end
                end
                default: begin
                    n.st = TWSP_IDLE;
                end
            endcase
        end

        // Stretch the low clock phase outside idle until software clears the flag
        n.scl_oe = n.flag & n.port_en & (n.st != TWSP_IDLE);
        n.irq    = n.flag & n.flag_en & irq_enable_low;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.st      <= TWSP_IDLE;
            q.ack_en  <= TWSP_SC_RST[TWSP_B_ACK_GENERATE_ENABLE];
            q.port_en <= TWSP_SC_RST[TWSP_B_EN];
            q.flag_en <= TWSP_SC_RST[TWSP_B_FEN];
            q.own     <= TWSP_OA_RST;
            q.shift   <= TWSP_DS_RST;
            q.scl_d   <= 1'b1;
            q.sda_d   <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign line_out.scl = 1'b0;
    assign line_out.sda = 1'b0;
    assign line_oe.scl  = q.scl_oe;
    assign line_oe.sda  = q.sda_oe;
    assign byte_irq     = q.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_tx_high;
        q.st == TWSP_TX && scl && q.scl_d;
    endsequence

    sequence seq_addr_hit;
        q.port_en && !start_ev && !stop_ev && q.st == TWSP_ADDR && scl_fall
            && q.cnt == TWSP_BYTE_BITS && addr_match;
    endsequence

    a_scl_hold_flag: assert property (
        q.flag && q.port_en && q.st != TWSP_IDLE |-> q.scl_oe
    ) else $error("clock line not held while flag set");

    a_nack_when_off: assert property (
        seq_addr_hit and !q.ack_en |=> !q.sda_oe
    ) else $error("acknowledge driven while disabled");

    a_addr_ack_dir: assert property (
        seq_addr_hit and q.ack_en |=> q.sda_oe && q.st == TWSP_ACK && q.address_match_status
            && q.dir == $past(q.shift[0])
    ) else $error("matching address not acknowledged");

    a_start_marks: assert property (
        q.port_en && start_ev |=> q.busy && !q.address_match_status && !q.gc && q.st == TWSP_ADDR
    ) else $error("start not recorded");

    a_stop_clears: assert property (
        q.port_en && !start_ev && stop_ev |=> !q.busy && q.st == TWSP_IDLE
    ) else $error("stop not recorded");

    a_own_locked: assert property (
        apb_wr && paddr == TWSP_ADDR_OA && q.port_en |=> $stable(q.own)
    ) else $error("own address written while enabled");

    a_data_locked: assert property (
        apb_wr && paddr == TWSP_ADDR_DS && !q.port_en |=> $stable(q.shift)
    ) else $error("data written while disabled");

    a_sda_stable: assert property (
        seq_tx_high |-> $stable(q.sda_oe)
    ) else $error("data changed with clock high");

    a_flag_on_ack: assert property (
        q.port_en && !start_ev && !stop_ev && q.st == TWSP_ACK && scl_fall
            && q.flag_en |=> q.flag ##1 q.scl_oe || !q.flag
    ) else $error("byte flag not raised");

    a_irq_gated: assert property (
        q.irq |-> q.flag && q.flag_en && $past(irq_enable_low)
    ) else $error("interrupt without both enables");

    a_apb_answer: assert property (
        apb_acc && !q.pready |=> q.pready ##1 !q.pready
    ) else $error("bus answer not in one wait state");

endmodule // twsp_port

// file: tb/twsp_master_model.sv
`timescale 1ns/1ps
module twsp_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // Slave may stretch a released clock; wait is bounded
    task automatic scl_up();
        int n;
        scl_oe = 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 3000) begin
            n++;
            #100;
        end
    endtask

    // Keep every line change off the sampling clock's edges
    task automatic align();
        #(125 - ($time % 100));
    endtask

    // Long low phase: the slave needs about 550 ns to show its next bit
    task automatic put_bit(input logic b, output logic seen);
        #100;
        sda_oe = ~b;
        #500;
        scl_up();
        #100;
        seen = sda;
        #100;
        scl_oe = 1'b1;
    endtask

    task automatic bus_start();
        align();
        sda_oe = 1'b0;
        #200;
        scl_up();
        #400;
        sda_oe = 1'b1;
        #400;
        scl_oe = 1'b1;
    endtask

    task automatic bus_stop();
        align();
        sda_oe = 1'b1;
        #200;
        scl_up();
        #400;
        sda_oe = 1'b0;
        #400;
    endtask

    // Long low phase after the ninth bit so the stretch lands first
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        align();
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, ack);
        #1000;
    endtask

    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        align();
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(~more, s);
        #1000;
    endtask
endmodule // twsp_master_model

// file: tb/twsp_port_tb.sv
`timescale 1ns/1ps
module twsp_port_tb;
    import twsp_pkg::*;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    twsp_line_t        line_in;
    twsp_line_t        line_out;
    twsp_line_t        line_oe;
    logic              irq_enable_low;
    logic              byte_irq;
    logic              m_scl_oe;
    logic              m_sda_oe;
    logic              ack;
    logic              err;
    logic [7:0]        rx;
    logic [31:0]       rdat;
    int                miscompares = 0;
    int                compares = 0;
    int                cycles = 0;

    // Open-drain wires with pull-ups
    assign line_in = {~(m_scl_oe | line_oe.scl), ~(m_sda_oe | line_oe.sda)};

    twsp_port #(.CLK_NS(100)) twsp_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe),
        .irq_enable_low(irq_enable_low), .byte_irq(byte_irq)
    );

    twsp_master_model twsp_master_model_inst (
        .scl(line_in.scl), .sda(line_in.sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
    );

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Look between edges so a freshly launched answer is not raced
        do begin
            @(negedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // The edge that samples ready high ends the transfer
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d, rdat, err);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        apb(a, 1'b0, 8'h00, rdat, err);
        check(name, rdat & {24'hFFFFFF, m}, {24'h0, exp & m});
    endtask

    // Flag, interrupt and clock hold at the end of a byte, then clear
    task automatic byte_end(input logic fl, input logic irq, input logic hold);
        rd_chk("byte_flag", TWSP_ADDR_FLAG, 8'h01, {7'h0, fl});
        @(negedge pclk);
        check("byte_irq", {31'h0, byte_irq}, {31'h0, irq});
        check("scl_hold", {31'h0, line_oe.scl}, {31'h0, hold});
        wr(TWSP_ADDR_FLAG, 8'h01);
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        check("scl_free", {31'h0, line_oe.scl}, 32'h0);
        @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        irq_enable_low = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("sc_reset", TWSP_ADDR_SC, 8'hFF, 8'h00);
        check("line_out", {30'h0, line_out}, 32'h0);
        apb(12'h000, 1'b0, 8'h00, rdat, err);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rdat, 32'h0);
        wr(TWSP_ADDR_DS, 8'h77);
        rd_chk("ds_locked", TWSP_ADDR_DS, 8'hFF, 8'h00);
        wr(TWSP_ADDR_OA, 8'h5A);
        rd_chk("oa_write", TWSP_ADDR_OA, 8'h7F, 8'h5A);
        wr(TWSP_ADDR_SC, 8'hE0);
        wr(TWSP_ADDR_OA, 8'h11);
        rd_chk("oa_locked", TWSP_ADDR_OA, 8'h7F, 8'h5A);
        wr(TWSP_ADDR_DS, 8'h3C);
        rd_chk("ds_write", TWSP_ADDR_DS, 8'hFF, 8'h3C);
        irq_enable_low <= 1'b1;
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h5A, 1'b0}, ack);
        check("addr_ack", {31'h0, ack}, 32'h0);
        rd_chk("sc_write", TWSP_ADDR_SC, 8'hFE, 8'hE6);
        byte_end(1'b1, 1'b1, 1'b1);
        irq_enable_low <= 1'b0;
        twsp_master_model_inst.send(8'hA5, ack);
        check("data_ack", {31'h0, ack}, 32'h0);
        rd_chk("rx_data", TWSP_ADDR_DS, 8'hFF, 8'hA5);
        byte_end(1'b1, 1'b0, 1'b1);
        irq_enable_low <= 1'b1;
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h5A, 1'b1}, ack);
        check("raddr_ack", {31'h0, ack}, 32'h0);
        rd_chk("sc_read", TWSP_ADDR_SC, 8'hFE, 8'hEE);
        wr(TWSP_ADDR_DS, 8'hC3);
        byte_end(1'b1, 1'b1, 1'b1);
        twsp_master_model_inst.recv(1'b1, rx);
        check("tx_first", {24'h0, rx}, 32'hC3);
        rd_chk("ninth_ack", TWSP_ADDR_SC, 8'h01, 8'h00);
        wr(TWSP_ADDR_DS, 8'h96);
        byte_end(1'b1, 1'b1, 1'b1);
        twsp_master_model_inst.recv(1'b0, rx);
        check("tx_last", {24'h0, rx}, 32'h96);
        rd_chk("ninth_nack", TWSP_ADDR_SC, 8'h01, 8'h01);
        byte_end(1'b1, 1'b1, 1'b0);
        twsp_master_model_inst.bus_stop();
        rd_chk("sc_stop", TWSP_ADDR_SC, 8'h06, 8'h00);
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send(8'h00, ack);
        check("gc_ack", {31'h0, ack}, 32'h0);
        rd_chk("gc_seen", TWSP_ADDR_SC, 8'h12, 8'h10);
        byte_end(1'b1, 1'b1, 1'b1);
        twsp_master_model_inst.bus_stop();
        rd_chk("gc_clear", TWSP_ADDR_SC, 8'h10, 8'h00);
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h33, 1'b0}, ack);
        check("other_nack", {31'h0, ack}, 32'h1);
        rd_chk("other_sam", TWSP_ADDR_SC, 8'h06, 8'h04);
        byte_end(1'b0, 1'b0, 1'b0);
        twsp_master_model_inst.bus_stop();
        wr(TWSP_ADDR_SC, 8'h60);
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h5A, 1'b0}, ack);
        check("ack_generate_enable_off", {31'h0, ack}, 32'h1);
        wr(TWSP_ADDR_FLAG, 8'h01);
        twsp_master_model_inst.bus_stop();
        wr(TWSP_ADDR_SC, 8'hC0);
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h5A, 1'b0}, ack);
        check("fen_off_ack", {31'h0, ack}, 32'h0);
        byte_end(1'b0, 1'b0, 1'b0);
        twsp_master_model_inst.send(8'h5C, ack);
        rd_chk("fen_off_rx", TWSP_ADDR_DS, 8'hFF, 8'h5C);
        twsp_master_model_inst.bus_stop();
        wr(TWSP_ADDR_SC, 8'h00);
        twsp_master_model_inst.bus_start();
        twsp_master_model_inst.send({7'h5A, 1'b0}, ack);
        check("off_nack", {31'h0, ack}, 32'h1);
        rd_chk("off_idle", TWSP_ADDR_SC, 8'h06, 8'h00);
        twsp_master_model_inst.bus_stop();
        stop_test();
    end
endmodule // twsp_port_tb
